// file: core/eeprom_link_regs.svh
// Constants shared by both ends of the two-wire serial EEPROM link.
// Assumes a single 50 MHz core clock in each end; the link pins are asynchronous to it.
//
// Operation
// - Device drives data line open-drain only
// - Sample on clock rise, change after fall
// - Write protect high blocks all array writes
// - 128 pages of 16 bytes, 11-bit address
// - Data moves only while clock low
// - Data fall with clock high is start
// - Data rise with clock high is stop
// - Eight-bit words, acknowledge on ninth clock
// - Standby at reset and after stop
// - Master recovers bus with nine clocks, start; code stops clocking once data samples high
// - Device address starts with type 1010
// - Three address bits are page select
// - Eighth address bit selects read or write
// - Match acknowledges, mismatch returns to standby
// - Byte write: word address, data, stop
// - Timed programming after stop ignores inputs
// - Page write takes up to 16 bytes
// - Page write wraps lower four address bits
// - Acknowledge polling answers after programming ends
// - Address counter keeps last address plus one
// - Read address word returns current byte
// - Dummy write then repeated start reads
// - Sequential read increments, wraps whole array
`ifndef EEPROM_LINK_REGS_SVH
`define EEPROM_LINK_REGS_SVH

// ============================================================
// Array geometry
`define ADDR_W          11
`define PAGE_OFS_W      4
`define PAGE_BYTES      16
`define MEM_BYTES       2048

// ============================================================
// Word framing
`define DEV_TYPE_CODE   4'hA
`define BYTE_BITS       4'h8
`define BYTE_SLOTS      4'h9
`define LAST_SLOT       4'h8

// ============================================================
// Timing
`define CORE_CLK_MHZ    50
`define PROG_TIME_US    3000
`define PROG_CNT_W      18
`define QUARTER_CYCLES  4
`define DIV_W           3

`endif

// file: core/eeprom_link_pkg.sv
// Types shared by both ends of the two-wire serial EEPROM link.
// Assumes eeprom_link_regs.svh is on the include path.
`include "eeprom_link_regs.svh"
`default_nettype none

package eeprom_link_pkg;

    // ============================================================
    // Device end
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_PROG
    } dev_state_type;

    typedef enum logic [1:0] {
        RK_DEV, RK_WORD, RK_DATA
    } rx_kind_type;

    typedef struct packed {
        dev_state_type           state;
        rx_kind_type             kind;
        logic [3:0]              cnt;
        logic [7:0]              shift;
        logic [`ADDR_W-1:0]      addr;
        logic                    rd;
        logic                    sda_oe;
        logic [`PAGE_BYTES-1:0]  mask;
        logic [`PROG_CNT_W-1:0]  prog;
    } dev_regs_type;

    // ============================================================
    // Master end
    typedef enum logic [2:0] {
        OP_START, OP_STOP, OP_WRITE, OP_READ, OP_RECOVER
    } mst_op_type;

    typedef enum logic {
        MS_IDLE, MS_RUN
    } mst_state_type;

    typedef struct packed {
        mst_state_type     state;
        mst_op_type        op;
        logic [3:0]        slot;
        logic [1:0]        ph;
        logic [`DIV_W-1:0] div;
        logic [8:0]        tx;
        logic [8:0]        rx;
        logic              scl_oe;
        logic              sda_oe;
        logic              rsp_valid;
        logic [7:0]        rsp_data;
        logic              rsp_nack;
    } mst_regs_type;

    // ============================================================
    // Synchroniser
    typedef struct packed {
        logic meta;
        logic level;
        logic prev;
    } sync_regs_type;

endpackage

`default_nettype wire

// file: core/two_wire_link_if.sv
// Open-drain two-wire link joining the master end and the device end.
// Assumes both lines are pulled high when nobody drives them low.
`default_nettype none

interface two_wire_link_if;
    // Master drivers
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    // Device drivers
    logic s_sda_o;
    logic s_sda_oe;
    // Resolved wired-AND levels
    logic scl;
    logic sda;

    assign scl = !(m_scl_oe && !m_scl_o);
    assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

    modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
    modport device (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

`default_nettype wire

// file: core/pin_sync.sv
// Two-flop synchroniser with edge detection for one link pin.
// Assumes the pin is asynchronous to core_clk; only level and prev feed logic, meta never does.
`default_nettype none

module pin_sync
    import eeprom_link_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // Pin and outputs
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    sync_regs_type r_q;
    sync_regs_type r_d;

    // ============================================================
    // Pins idle high, so reset to high avoids a false edge
    always_comb begin
        r_d       = r_q;
        r_d.meta  = pin_in;
        r_d.level = r_q.meta;
        r_d.prev  = r_q.level;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_q <= '{meta: 1'b1, level: 1'b1, prev: 1'b1};
        end else begin
            r_q <= r_d;
        end
    end

    assign level = r_q.level;
    assign rise  = r_q.level && !r_q.prev;
    assign fall  = !r_q.level && r_q.prev;
endmodule

`default_nettype wire

// file: core/eeprom_slave_end.sv
// Device end: two-wire serial EEPROM slave with page buffer and timed programming.
// Assumes the link pins and write protect are asynchronous and pass pin_sync first.
`include "eeprom_link_regs.svh"
`default_nettype none

module eeprom_slave_end
    import eeprom_link_pkg::*;
#(
    parameter int PROG_CYCLES = `PROG_TIME_US * `CORE_CLK_MHZ
)(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Two-wire link
    two_wire_link_if.device link,
    // Protection pin
    input  wire logic       write_protect,
    // Status
    output logic            standby,
    output logic            prog_busy
);
    localparam logic [`PROG_CNT_W-1:0] PROG_LAST = `PROG_CNT_W'(PROG_CYCLES - 1);

    dev_regs_type r_q;
    dev_regs_type r_d;

    logic [7:0] mem_q  [0:`MEM_BYTES-1];
    logic [7:0] page_q [0:`PAGE_BYTES-1];

    logic       scl_lvl;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda_lvl;
    logic       sda_rise;
    logic       sda_fall;
    logic       wp_lvl;
    logic       start_cond;
    logic       stop_cond;
    logic       page_we;
    logic       commit;
    logic [7:0] rd_byte;

    // ============================================================
    // Pin synchronisers
    pin_sync u_scl (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (link.scl),
        .level    (scl_lvl),
        .rise     (scl_rise),
        .fall     (scl_fall)
    );

    pin_sync u_sda (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (link.sda),
        .level    (sda_lvl),
        .rise     (sda_rise),
        .fall     (sda_fall)
    );

    pin_sync u_wp (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (write_protect),
        .level    (wp_lvl),
        .rise     (),
        .fall     ()
    );

    // Both pins share the same sync delay, so edges stay ordered
    assign start_cond = scl_lvl && sda_fall;
    assign stop_cond  = scl_lvl && sda_rise;

    // ============================================================
    // Protocol engine
    always_comb begin
        r_d     = r_q;
        page_we = 1'b0;
        commit  = 1'b0;
        rd_byte = mem_q[r_q.addr];
        if (r_q.state == ST_PROG) begin
            // Deaf to the link, so polling gets no acknowledge
            if (r_q.prog == PROG_LAST) begin
                commit    = 1'b1;
                r_d.mask  = '0;
                r_d.state = ST_IDLE;
            end else begin
                r_d.prog = r_q.prog + `PROG_CNT_W'(1);
            end
        end else if (start_cond) begin
            r_d.state  = ST_RX;
            r_d.kind   = RK_DEV;
            r_d.cnt    = 4'h0;
            r_d.sda_oe = 1'b0;
            r_d.mask   = '0;
        end else if (stop_cond) begin
            r_d.sda_oe = 1'b0;
            if (r_q.mask != '0 && !wp_lvl) begin
                r_d.state = ST_PROG;
                r_d.prog  = '0;
            end else begin
                // Drop protected bytes so a later stop cannot commit them
                r_d.mask  = '0;
                r_d.state = ST_IDLE;
            end
        end else begin
            case (r_q.state)
                ST_RX: begin
                    if (scl_rise) begin
                        r_d.shift = {r_q.shift[6:0], sda_lvl};
                        r_d.cnt   = r_q.cnt + 4'h1;
                    end else if (scl_fall && r_q.cnt == `BYTE_BITS) begin
                        r_d.sda_oe = 1'b1;
                        r_d.state  = ST_ACK;
                        case (r_q.kind)
                            RK_DEV: begin
                                if (r_q.shift[7:4] == `DEV_TYPE_CODE) begin
                                    r_d.addr[10:8] = r_q.shift[3:1];
                                    r_d.rd         = r_q.shift[0];
                                    r_d.kind       = RK_WORD;
                                end else begin
                                    r_d.sda_oe = 1'b0;
                                    r_d.state  = ST_IDLE;
                                end
                            end
                            RK_WORD: begin
                                r_d.addr[7:0] = r_q.shift;
                                r_d.kind      = RK_DATA;
                            end
                            default: begin
                                // Bytes gather in the page buffer; protect only blocks commit
                                page_we = 1'b1;
                                r_d.mask[r_q.addr[3:0]] = 1'b1;
                                r_d.addr[3:0] = r_q.addr[3:0] + 4'h1;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (r_q.rd) begin
                            r_d.shift  = rd_byte;
                            r_d.sda_oe = !rd_byte[7];
                            r_d.addr   = r_q.addr + `ADDR_W'(1);
                            r_d.cnt    = 4'h1;
                            r_d.state  = ST_TX;
                        end else begin
                            r_d.sda_oe = 1'b0;
                            r_d.cnt    = 4'h0;
                            r_d.state  = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (r_q.cnt == `BYTE_BITS) begin
                            r_d.sda_oe = 1'b0;
                            r_d.state  = ST_MACK;
                        end else begin
                            r_d.sda_oe = !r_q.shift[6];
                            r_d.shift  = {r_q.shift[6:0], 1'b0};
                            r_d.cnt    = r_q.cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        // Master low means another byte; high ends the read
                        r_d.state = sda_lvl ? ST_IDLE : ST_ACK;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_q <= '{state: ST_IDLE, kind: RK_DEV, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // ============================================================
    // Array and page buffer; contents have no reset, like the cells
    always_ff @(posedge core_clk) begin
        if (page_we) begin
            page_q[r_q.addr[3:0]] <= r_q.shift;
        end
        if (commit) begin
            for (int i = 0; i < `PAGE_BYTES; i++) begin
                if (r_q.mask[i]) begin
                    mem_q[{r_q.addr[10:4], 4'(i)}] <= page_q[i];
                end
            end
        end
    end

    // ============================================================
    // Outputs
    assign link.s_sda_o  = 1'b0;
    assign link.s_sda_oe = r_q.sda_oe;
    assign standby       = (r_q.state == ST_IDLE);
    assign prog_busy     = (r_q.state == ST_PROG);
endmodule

`default_nettype wire

// file: core/bus_master_end.sv
// Master end: drives the serial clock and runs start, stop, byte and recovery commands.
// Assumes one command at a time from user logic on core_clk.
`include "eeprom_link_regs.svh"
`default_nettype none

module bus_master_end
    import eeprom_link_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Two-wire link
    two_wire_link_if.master  link,
    // Command
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire mst_op_type  cmd_op,
    input  wire logic [7:0]  cmd_data,
    input  wire logic        cmd_ack,
    // Response
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_nack
);
    mst_regs_type r_q;
    mst_regs_type r_d;

    logic       sda_lvl;
    logic       tick;
    logic       cond;
    logic       last;
    logic [8:0] rx_new;

    pin_sync u_sda (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pin_in   (link.sda),
        .level    (sda_lvl),
        .rise     (),
        .fall     ()
    );

    // ============================================================
    // Each slot: fall, data change, rise, sample at the end of high
    always_comb begin
        r_d           = r_q;
        r_d.rsp_valid = 1'b0;
        tick          = (r_q.div == `DIV_W'(`QUARTER_CYCLES - 1));
        cond          = (r_q.op == OP_START) || (r_q.op == OP_STOP);
        rx_new        = {r_q.rx[7:0], sda_lvl};
        last          = 1'b0;
        case (r_q.state)
            MS_IDLE: begin
                if (cmd_valid) begin
                    r_d.state  = MS_RUN;
                    r_d.op     = cmd_op;
                    r_d.slot   = 4'h0;
                    r_d.ph     = 2'h0;
                    r_d.div    = '0;
                    r_d.scl_oe = 1'b1;
                    case (cmd_op)
                        OP_START: r_d.tx = 9'h100;
                        OP_STOP:  r_d.tx = 9'h000;
                        OP_WRITE: r_d.tx = {cmd_data, 1'b1};
                        OP_READ:  r_d.tx = {8'hFF, !cmd_ack};
                        default:  r_d.tx = 9'h1FF;
                    endcase
                end
            end
            MS_RUN: begin
                r_d.div = tick ? '0 : r_q.div + `DIV_W'(1);
                if (tick) begin
                    r_d.ph = r_q.ph + 2'h1;
                    case (r_q.ph)
                        2'h0: r_d.sda_oe = !r_q.tx[8];
                        2'h1: r_d.scl_oe = 1'b0;
                        2'h2: r_d.sda_oe = cond ? r_q.tx[8] : !r_q.tx[8];
                        default: begin
                            r_d.rx = rx_new;
                            r_d.tx = {r_q.tx[7:0], 1'b1};
                            if (r_q.op == OP_RECOVER) begin
                                last = sda_lvl || (r_q.slot == `LAST_SLOT);
                            end else if (cond) begin
                                last = 1'b1;
                            end else begin
                                last = (r_q.slot == `LAST_SLOT);
                            end
                            if (last) begin
                                r_d.state     = MS_IDLE;
                                r_d.rsp_valid = !cond;
                                r_d.rsp_data  = rx_new[8:1];
                                r_d.rsp_nack  = rx_new[0];
                            end else begin
                                r_d.scl_oe = 1'b1;
                                r_d.slot   = r_q.slot + 4'h1;
                            end
                        end
                    endcase
                end
            end
            default: r_d.state = MS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_q <= '{state: MS_IDLE, op: OP_START, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // ============================================================
    // Outputs
    assign cmd_ready     = (r_q.state == MS_IDLE);
    assign rsp_valid     = r_q.rsp_valid;
    assign rsp_data      = r_q.rsp_data;
    assign rsp_nack      = r_q.rsp_nack;
    assign link.m_scl_o  = 1'b0;
    assign link.m_sda_o  = 1'b0;
    assign link.m_scl_oe = r_q.scl_oe;
    assign link.m_sda_oe = r_q.sda_oe;
endmodule

`default_nettype wire

// file: tb/eeprom_link_asserts.sv
// Checker for the device side of the two-wire link.
// Assumes tb_top instantiates it beside the link interface, one core clock domain.
`default_nettype none

module eeprom_link_asserts #(
    parameter int PROG_CYCLES = 200
)(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // Link
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic s_sda_o,
    input  wire logic s_sda_oe,
    // Device pins and status
    input  wire logic write_protect,
    input  wire logic standby,
    input  wire logic prog_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // Programming length counter
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;

    always_comb begin
        busy_cnt_d = prog_busy ? busy_cnt_q + 32'h1 : 32'h0;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    // ============================================================
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    open_drain_a: assert property (s_sda_o == 1'b0)
        else $error("device drives data line high");
    change_low_a: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("device data moved with clock high");
    hold_high_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
        else $error("device data not held while clock high");
    quiet_busy_a: assert property (prog_busy |-> !s_sda_oe)
        else $error("device answered while programming");
    busy_standby_a: assert property (prog_busy |-> !standby)
        else $error("standby during programming");
    wp_no_prog_a: assert property ($rose(prog_busy) |-> !write_protect)
        else $error("programming began while protected");
    prog_after_stop_a: assert property ($rose(prog_busy) |-> scl && sda)
        else $error("programming began without a stop");
    prog_len_a: assert property ($fell(prog_busy) |->
        busy_cnt_q >= 32'(PROG_CYCLES - 1) && busy_cnt_q <= 32'(PROG_CYCLES + 1))
        else $error("programming time wrong");
    stop_standby_a: assert property (scl && $rose(sda) && !prog_busy |->
        ##[1:8] (standby || prog_busy))
        else $error("no standby after stop");
endmodule

`default_nettype wire

// file: tb/tb_top.sv
// Testbench joining both link ends, with a byte-level model of the array.
// Assumes the core package and interface are compiled first.
`default_nettype none

module tb_top
    import eeprom_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // Signals
    localparam int PROG_N = 200;
    logic       core_clk;
    logic       rst_b;
    logic       write_protect;
    logic       cmd_valid;
    logic       cmd_ack;
    mst_op_type cmd_op;
    logic [7:0] cmd_data;
    logic       cmd_ready;
    logic       rsp_valid;
    logic       rsp_nack;
    logic [7:0] rsp_data;
    logic       standby;
    logic       prog_busy;
    int         errors;
    int         compares;
    int         ptr;
    logic [7:0] mem_m [0:2047];

    two_wire_link_if two_wire_link_if_i ();

    eeprom_slave_end #(.PROG_CYCLES(PROG_N)) eeprom_slave_end_i (
        .core_clk(core_clk), .rst_b(rst_b), .link(two_wire_link_if_i),
        .write_protect(write_protect), .standby(standby), .prog_busy(prog_busy));

    bus_master_end bus_master_end_i (
        .core_clk(core_clk), .rst_b(rst_b), .link(two_wire_link_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_nack(rsp_nack));

    eeprom_link_asserts #(.PROG_CYCLES(PROG_N)) eeprom_link_asserts_i (
        .core_clk(core_clk), .rst_b(rst_b), .scl(two_wire_link_if_i.scl),
        .sda(two_wire_link_if_i.sda), .s_sda_o(two_wire_link_if_i.s_sda_o),
        .s_sda_oe(two_wire_link_if_i.s_sda_oe), .write_protect(write_protect),
        .standby(standby), .prog_busy(prog_busy));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ============================================================
    // Tasks
    task automatic complete_run();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // rsp_valid pulses as ready returns and the other response fields stand, so waiting for ready again is enough
    task automatic issue(input mst_op_type op, input logic [7:0] d, input logic ack);
        int n;
        n = 0;
        @(negedge core_clk);
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_data = d;
        cmd_ack = ack;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        check({7'h0, rsp_valid}, {7'h0, op != OP_START && op != OP_STOP});
        check(8'(n >= 400), 8'h00);
    endtask

    task automatic wr(input logic [7:0] b, input logic exp_nack);
        issue(OP_WRITE, b, 1'b0);
        check({7'h0, rsp_nack}, {7'h0, exp_nack});
    endtask

    task automatic dev(input logic [10:0] a, input logic rd, input logic exp_nack);
        issue(OP_START, 8'h00, 1'b0);
        wr({4'hA, a[10:8], rd}, exp_nack);
    endtask

    task automatic idle_check();
        repeat (4) @(negedge core_clk);
        check({7'h0, standby}, 8'h01);
    endtask

    task automatic write_seq(input logic [10:0] a, input int n);
        logic [7:0]  b;
        logic [10:0] p;
        int          k;
        p = a;
        dev(a, 1'b0, 1'b0);
        wr(a[7:0], 1'b0);
        for (k = 0; k < n; k++) begin
            b = 8'($urandom());
            wr(b, 1'b0);
            if (!write_protect) mem_m[p] = b;
            p = {p[10:4], p[3:0] + 4'h1};
        end
        ptr = int'(p);
        issue(OP_STOP, 8'h00, 1'b0);
        check({7'h0, prog_busy}, {7'h0, !write_protect});
        dev(a, 1'b0, !write_protect);
        // One poll is shorter than programming, so wait the full count
        repeat (PROG_N) @(negedge core_clk);
        dev(a, 1'b0, 1'b0);
        check({7'h0, rsp_nack}, 8'h00);
        issue(OP_STOP, 8'h00, 1'b0);
        idle_check();
    endtask

    task automatic read_seq(input logic [10:0] a, input logic rnd, input int n);
        int k;
        if (rnd) begin
            dev(a, 1'b0, 1'b0);
            wr(a[7:0], 1'b0);
            ptr = int'(a);
        end
        dev(11'(ptr), 1'b1, 1'b0);
        for (k = 0; k < n; k++) begin
            issue(OP_READ, 8'h00, k < n - 1);
            check(rsp_data, mem_m[ptr]);
            ptr = (ptr + 1) % 2048;
        end
        issue(OP_STOP, 8'h00, 1'b0);
        idle_check();
    endtask

    // ============================================================
    // Sequence
    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        complete_run();
    end

    initial begin
        logic [7:0] bad [3];
        bad = '{8'h50, 8'hB0, 8'h20};
        void'($urandom(19));
        errors = 0;
        compares = 0;
        ptr = 0;
        rst_b = 1'b0;
        write_protect = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = OP_START;
        cmd_data = 8'h00;
        cmd_ack = 1'b0;
        repeat (16) @(negedge core_clk);
        check({7'h0, standby}, 8'h01);
        check({7'h0, prog_busy}, 8'h00);
        rst_b = 1'b1;
        issue(OP_RECOVER, 8'h00, 1'b0);
        check({7'h0, rsp_nack}, 8'h01);
        foreach (bad[i]) begin
            issue(OP_START, 8'h00, 1'b0);
            wr(bad[i], 1'b1);
            idle_check();
        end
        issue(OP_STOP, 8'h00, 1'b0);
        write_seq(11'h7FF, 1);
        write_seq(11'h00E, 18);
        read_seq(11'h7FF, 1'b1, 3);
        read_seq(11'h000, 1'b0, 2);
        read_seq(11'h000, 1'b1, 16);
        // Protect pin passes a synchroniser, so let it settle first
        write_protect = 1'b1;
        repeat (8) @(negedge core_clk);
        write_seq(11'h005, 2);
        write_protect = 1'b0;
        repeat (8) @(negedge core_clk);
        read_seq(11'h005, 1'b1, 2);
        complete_run();
    end
endmodule

`default_nettype wire
